// File: rtl/irq_pkg.sv
// Functional notes
// - no peripheral request reaches cpu_irq_o unless the peripheral enable bit is set; irq_o does not depend on that bit.
// - every flag sets on its condition whatever its enable and the global enable hold.
// - request one bit 7 reads 1 while the timer one gate is inactive, 0 while active.
// - request one bit 6 sets on conversion done and stays set until software clears it.
// - request one bit 5 is read-only, resets to 0, and reads 1 while the receive buffer holds data.
// - request one bit 4 is read-only and reads 1 while the transmit buffer is empty.
// - request one bit 3 sets when a sync port transfer completes and needs a software clear.
// - request one bit 2 sets on capture or compare of unit one, needs a clear, unused in pwm mode.
// - request one bit 1 sets when timer two matches its period register.
// - request one bit 0 sets on timer one overflow and stays set until cleared.
// - enable one holds one enable per source in the same bit positions as request one.
package irq_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // -------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_CONTROL = 8'h00;
  localparam logic [7:0] OFS_OPTION       = 8'h01;
  localparam logic [7:0] OFS_ENABLE_ONE   = 8'h02;
  localparam logic [7:0] OFS_ENABLE_TWO   = 8'h03;
  localparam logic [7:0] OFS_REQUEST_ONE  = 8'h04;
  localparam logic [7:0] OFS_REQUEST_TWO  = 8'h05;
  localparam logic [7:0] OFS_STATUS_ONE   = 8'h06;
  localparam logic [7:0] OFS_STATUS_TWO   = 8'h07;
  localparam logic [7:0] OFS_MASK_ONE     = 8'h08;
  localparam logic [7:0] OFS_MASK_TWO     = 8'h09;

  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int unsigned BIT_GLOBAL_EN     = 7;
  localparam int unsigned BIT_PERIPH_EN     = 6;
  localparam int unsigned BIT_GATE          = 7;
  localparam int unsigned BIT_CONV_DONE     = 6;
  localparam int unsigned BIT_RX_FULL       = 5;
  localparam int unsigned BIT_TX_EMPTY      = 4;
  localparam int unsigned BIT_SYNC_DONE     = 3;
  localparam int unsigned BIT_CAPCOMP_ONE   = 2;
  localparam int unsigned BIT_TIMER_TWO     = 1;
  localparam int unsigned BIT_TIMER_ONE_OVF = 0;
  localparam int unsigned BIT_CAPCOMP_TWO   = 0;

  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;
  localparam logic [7:0] RST_OPTION       = 8'h00;
  localparam logic [7:0] RST_ENABLE       = 8'h00;
  localparam logic [7:0] RST_STATUS       = 8'h00;
  localparam logic [7:0] RST_MASK         = 8'h00;
  localparam logic [1:0] RST_SYNC         = 2'h0;
  // request one at rest: gate bit high while the gate is inactive
  localparam logic [7:0] RST_REQ_ONE_IDLE = 8'h80;

  // software-clearable flags: five in request one plus unit two
  localparam int unsigned NUM_STICKY = 6;

endpackage

// File: rtl/flag_if.sv
`timescale 1ns/100ps
`default_nettype none
interface flag_if;
  logic set;
  logic wr;
  logic wdata;
  logic q;
  modport owner (input set, input wr, input wdata, output q);
  modport user  (output set, output wr, output wdata, input q);
endinterface
`default_nettype wire

// File: rtl/sticky_flag.sv
`timescale 1ns/100ps
`default_nettype none
module sticky_flag
  import irq_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  flag_if.owner     flag
);

  // set dominates so an event in the clearing cycle survives
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag.q <= 1'b0;
    end else if (flag.set) begin
      flag.q <= 1'b1;
    end else if (flag.wr) begin
      flag.q <= flag.wdata;
    end
  end

endmodule
`default_nettype wire

// File: rtl/peripheral_irq_flags_enables.sv
`timescale 1ns/100ps
`default_nettype none
module peripheral_irq_flags_enables
  import irq_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              timer_one_gate_active_i,
  input  wire logic              conversion_done_i,
  input  wire logic              async_receive_full_i,
  input  wire logic              async_transmit_empty_i,
  input  wire logic              sync_port_done_i,
  input  wire logic              capcomp_one_event_i,
  input  wire logic              capcomp_one_pwm_i,
  input  wire logic              timer_two_match_i,
  input  wire logic              timer_one_overflow_i,
  input  wire logic              capcomp_two_event_i,
  input  wire logic              capcomp_two_pwm_i,
  output logic                   cpu_irq_o,
  output logic                   irq_o
);

  // -------------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= RST_SYNC;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // -------------------------------------------------------------------
  // write decode
  // -------------------------------------------------------------------
  logic wr_main;
  logic wr_option;
  logic wr_en_one;
  logic wr_en_two;
  logic wr_req_one;
  logic wr_req_two;
  logic wr_stat_one;
  logic wr_stat_two;
  logic wr_mask_one;
  logic wr_mask_two;

  assign wr_main     = wr_i && (addr_i == OFS_MAIN_CONTROL);
  assign wr_option   = wr_i && (addr_i == OFS_OPTION);
  assign wr_en_one   = wr_i && (addr_i == OFS_ENABLE_ONE);
  assign wr_en_two   = wr_i && (addr_i == OFS_ENABLE_TWO);
  assign wr_req_one  = wr_i && (addr_i == OFS_REQUEST_ONE);
  assign wr_req_two  = wr_i && (addr_i == OFS_REQUEST_TWO);
  assign wr_stat_one = wr_i && (addr_i == OFS_STATUS_ONE);
  assign wr_stat_two = wr_i && (addr_i == OFS_STATUS_TWO);
  assign wr_mask_one = wr_i && (addr_i == OFS_MASK_ONE);
  assign wr_mask_two = wr_i && (addr_i == OFS_MASK_TWO);

  // -------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------
  logic                global_irq_enable_q;
  logic                peripheral_irq_enable_q;
  logic [DATA_W-1:0]   option_settings_q;
  logic [DATA_W-1:0]   peripheral_enable_one_q;
  logic                capcomp_two_irq_enable_q;

  // core-source bits of the main control register live elsewhere
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable_q <= RST_MAIN_CONTROL[BIT_GLOBAL_EN];
    end else if (wr_main) begin
      global_irq_enable_q <= wdata_i[BIT_GLOBAL_EN];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_irq_enable_q <= RST_MAIN_CONTROL[BIT_PERIPH_EN];
    end else if (wr_main) begin
      peripheral_irq_enable_q <= wdata_i[BIT_PERIPH_EN];
    end
  end

  // timer and pin options are only stored here
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      option_settings_q <= RST_OPTION;
    end else if (wr_option) begin
      option_settings_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_enable_one_q <= RST_ENABLE;
    end else if (wr_en_one) begin
      peripheral_enable_one_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      capcomp_two_irq_enable_q <= RST_ENABLE[BIT_CAPCOMP_TWO];
    end else if (wr_en_two) begin
      capcomp_two_irq_enable_q <= wdata_i[BIT_CAPCOMP_TWO];
    end
  end

  // -------------------------------------------------------------------
  // sticky request flags
  // -------------------------------------------------------------------
  logic [NUM_STICKY-1:0] flag_set;
  logic [NUM_STICKY-1:0] flag_wr;
  logic [NUM_STICKY-1:0] flag_wdata;
  logic [NUM_STICKY-1:0] flag_q;

  // flags set regardless of any enable bit
  assign flag_set[0] = conversion_done_i;
  assign flag_set[1] = sync_port_done_i;
  // pwm mode produces no capture or compare events
  assign flag_set[2] = capcomp_one_event_i && !capcomp_one_pwm_i;
  assign flag_set[3] = timer_two_match_i;
  assign flag_set[4] = timer_one_overflow_i;
  assign flag_set[5] = capcomp_two_event_i && !capcomp_two_pwm_i;

  assign flag_wr[0]    = wr_req_one;
  assign flag_wr[1]    = wr_req_one;
  assign flag_wr[2]    = wr_req_one;
  assign flag_wr[3]    = wr_req_one;
  assign flag_wr[4]    = wr_req_one;
  assign flag_wr[5]    = wr_req_two;
  assign flag_wdata[0] = wdata_i[BIT_CONV_DONE];
  assign flag_wdata[1] = wdata_i[BIT_SYNC_DONE];
  assign flag_wdata[2] = wdata_i[BIT_CAPCOMP_ONE];
  assign flag_wdata[3] = wdata_i[BIT_TIMER_TWO];
  assign flag_wdata[4] = wdata_i[BIT_TIMER_ONE_OVF];
  assign flag_wdata[5] = wdata_i[BIT_CAPCOMP_TWO];

  // -------------------------------------------------------------------
  // one sticky cell per software-clearable flag
  // -------------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < NUM_STICKY; gi++) begin : g_flag
      flag_if fl ();
      assign fl.set   = flag_set[gi];
      assign fl.wr    = flag_wr[gi];
      assign fl.wdata = flag_wdata[gi];
      assign flag_q[gi] = fl.q;
      sticky_flag u_flag (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .flag    (fl)
      );
    end
  endgenerate

  // -------------------------------------------------------------------
  // request register views
  // -------------------------------------------------------------------
  logic [DATA_W-1:0] request_one;
  logic [DATA_W-1:0] request_two;

  // live levels are owned by their peripherals; writes do not touch them
  always_comb begin
    request_one                    = '0;
    request_one[BIT_GATE]          = !timer_one_gate_active_i;
    request_one[BIT_CONV_DONE]     = flag_q[0];
    request_one[BIT_RX_FULL]       = async_receive_full_i;
    request_one[BIT_TX_EMPTY]      = async_transmit_empty_i;
    request_one[BIT_SYNC_DONE]     = flag_q[1];
    request_one[BIT_CAPCOMP_ONE]   = flag_q[2];
    request_one[BIT_TIMER_TWO]     = flag_q[3];
    request_one[BIT_TIMER_ONE_OVF] = flag_q[4];
  end

  // unit two sits alone at bit 0; the upper bits read zero
  always_comb begin
    request_two                    = '0;
    request_two[BIT_CAPCOMP_TWO]   = flag_q[5];
  end

  // -------------------------------------------------------------------
  // event status and mask
  // -------------------------------------------------------------------
  logic [DATA_W-1:0] req_one_prev_q;
  logic              req_two_prev_q;
  logic [DATA_W-1:0] status_one_q;
  logic              status_two_q;
  logic [DATA_W-1:0] mask_one_q;
  logic              mask_two_q;
  logic [DATA_W-1:0] rise_one;
  logic              rise_two;

  // prev regs track requests so that level sources log one event;
  // reset to the idle levels, else the gate bit logs a false edge
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_one_prev_q <= RST_REQ_ONE_IDLE;
    end else begin
      req_one_prev_q <= request_one;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_two_prev_q <= RST_STATUS[0];
    end else begin
      req_two_prev_q <= request_two[BIT_CAPCOMP_TWO];
    end
  end

  assign rise_one = request_one & ~req_one_prev_q;
  assign rise_two = request_two[BIT_CAPCOMP_TWO] && !req_two_prev_q;

  // write one to clear; a new event in that cycle wins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_one_q <= RST_STATUS;
    end else if (wr_stat_one) begin
      status_one_q <= (status_one_q & ~wdata_i) | rise_one;
    end else begin
      status_one_q <= status_one_q | rise_one;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_two_q <= RST_STATUS[0];
    end else if (wr_stat_two) begin
      // a rise in the clearing cycle survives
      status_two_q <= (status_two_q && !wdata_i[0]) || rise_two;
    end else begin
      status_two_q <= status_two_q || rise_two;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_one_q <= RST_MASK;
    end else if (wr_mask_one) begin
      mask_one_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_two_q <= RST_MASK[0];
    end else if (wr_mask_two) begin
      mask_two_q <= wdata_i[0];
    end
  end

  // -------------------------------------------------------------------
  // enable and mask gating
  // -------------------------------------------------------------------
  logic [DATA_W-1:0] match_one;
  logic              match_two;
  logic [DATA_W-1:0] armed_one;
  logic              armed_two;
  logic              pending;

  // live bits 7, 5 and 4 interrupt for as long as their level holds;
  // software silences them through the enable, not by a write
  assign match_one = request_one & peripheral_enable_one_q;
  assign match_two = request_two[BIT_CAPCOMP_TWO] && capcomp_two_irq_enable_q;
  assign armed_one = status_one_q & mask_one_q;
  assign armed_two = status_two_q && mask_two_q;
  assign pending   = (|match_one) || match_two;

  // -------------------------------------------------------------------
  // interrupt outputs
  // -------------------------------------------------------------------

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cpu_irq_o <= 1'b0;
    end else begin
      // peripheral enable gates both request registers
      cpu_irq_o <= global_irq_enable_q && peripheral_irq_enable_q
                   && pending;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (|armed_one) || armed_two;
    end
  end

  // -------------------------------------------------------------------
  // read port
  // -------------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  // reads have no side effects; live bits show as they stand
  always_comb begin
    rd_mux = '0;
    case (addr_i)
      OFS_MAIN_CONTROL: begin
        rd_mux[BIT_GLOBAL_EN] = global_irq_enable_q;
        rd_mux[BIT_PERIPH_EN] = peripheral_irq_enable_q;
      end
      OFS_OPTION:      rd_mux = option_settings_q;
      OFS_ENABLE_ONE:  rd_mux = peripheral_enable_one_q;
      OFS_ENABLE_TWO:  rd_mux[BIT_CAPCOMP_TWO] = capcomp_two_irq_enable_q;
      OFS_REQUEST_ONE: rd_mux = request_one;
      OFS_REQUEST_TWO: rd_mux = request_two;
      OFS_STATUS_ONE:  rd_mux = status_one_q;
      OFS_STATUS_TWO:  rd_mux[0] = status_two_q;
      OFS_MASK_ONE:    rd_mux = mask_one_q;
      OFS_MASK_TWO:    rd_mux[0] = mask_two_q;
      default:         rd_mux = '0;
    endcase
  end

  // data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= '0;
    end
  end

endmodule
`default_nettype wire

// File: verif/irq_flags_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module irq_flags_monitor
  import irq_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              timer_one_gate_active_i,
  input wire logic              conversion_done_i,
  input wire logic              async_receive_full_i,
  input wire logic              async_transmit_empty_i,
  input wire logic              sync_port_done_i,
  input wire logic              capcomp_one_event_i,
  input wire logic              capcomp_one_pwm_i,
  input wire logic              timer_two_match_i,
  input wire logic              timer_one_overflow_i,
  input wire logic              capcomp_two_event_i,
  input wire logic              capcomp_two_pwm_i,
  input wire logic              cpu_irq_o,
  input wire logic              irq_o
);
  logic       ge_q;
  logic       pe_q;
  logic [7:0] en1_q;

  // ---------------------------------------------------------------
  // shadow of the enables, mirrored from bus writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ge_q  <= 1'b0;
      pe_q  <= 1'b0;
      en1_q <= 8'h00;
    end else if (wr_i && addr_i == OFS_MAIN_CONTROL) begin
      ge_q <= wdata_i[BIT_GLOBAL_EN];
      pe_q <= wdata_i[BIT_PERIPH_EN];
    end else if (wr_i && addr_i == OFS_ENABLE_ONE) begin
      en1_q <= wdata_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_periph_gate: assert property (
    !pe_q |=> !cpu_irq_o) else $error("cpu request without periph enable");
  a_global_gate: assert property (
    !ge_q |=> !cpu_irq_o) else $error("cpu request without global enable");
  a_ovf_to_cpu: assert property (
    timer_one_overflow_i && ge_q && pe_q && en1_q[BIT_TIMER_ONE_OVF]
    && !wr_i ##1 !wr_i |=> cpu_irq_o) else $error("overflow not forwarded");
  a_conv_to_cpu: assert property (
    conversion_done_i && ge_q && pe_q && en1_q[BIT_CONV_DONE]
    && !wr_i ##1 !wr_i |=> cpu_irq_o) else $error("conversion not forwarded");
  a_en_two_upper: assert property (
    rd_i && addr_i == OFS_ENABLE_TWO |=> rdata_o[7:1] == 7'h00)
    else $error("enable two upper bits not zero");
  a_req_two_upper: assert property (
    rd_i && addr_i == OFS_REQUEST_TWO |=> rdata_o[7:1] == 7'h00)
    else $error("request two upper bits not zero");
  a_gate_live: assert property (
    rd_i && addr_i == OFS_REQUEST_ONE
    |=> rdata_o[BIT_GATE] == !$past(timer_one_gate_active_i))
    else $error("gate bit wrong");
  a_rx_live: assert property (
    rd_i && addr_i == OFS_REQUEST_ONE
    |=> rdata_o[BIT_RX_FULL] == $past(async_receive_full_i))
    else $error("receive bit wrong");
  a_tx_live: assert property (
    rd_i && addr_i == OFS_REQUEST_ONE
    |=> rdata_o[BIT_TX_EMPTY] == $past(async_transmit_empty_i))
    else $error("transmit bit wrong");

  c_cpu_irq: cover property (cpu_irq_o);
  c_irq: cover property (irq_o);
  c_req_read: cover property (rd_i && addr_i == OFS_REQUEST_ONE);
endmodule

bind peripheral_irq_flags_enables irq_flags_monitor mon_u (
  .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .timer_one_gate_active_i, .conversion_done_i, .async_receive_full_i,
  .async_transmit_empty_i, .sync_port_done_i, .capcomp_one_event_i,
  .capcomp_one_pwm_i, .timer_two_match_i, .timer_one_overflow_i,
  .capcomp_two_event_i, .capcomp_two_pwm_i, .cpu_irq_o, .irq_o
);
`default_nettype wire

// File: verif/periph_model.sv
`timescale 1ns/100ps
`default_nettype none
module periph_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] ev_i,
  input  wire logic [4:0] lvl_i,
  output logic      [5:0] ev_o,
  output logic      [4:0] lvl_o
);
  // ---------------------------------------------------------------
  // conditions leave the peripherals on a clock edge, one cycle after the bench drives them
  // ---------------------------------------------------------------
  initial ev_o = 6'h00;
  initial lvl_o = 5'h00;
  always @(posedge clk_i) begin
    ev_o  <= ev_i;
    lvl_o <= lvl_i;
  end
endmodule
`default_nettype wire

// File: verif/peripheral_irq_flags_enables_tb.sv
`timescale 1ns/100ps
`default_nettype none
module peripheral_irq_flags_enables_tb
  import irq_pkg::*;
;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic       cpu_irq_o;
  logic       irq_o;
  logic [5:0] ev = 6'h00;
  logic [4:0] lvl = 5'h00;
  logic [5:0] ev_m;
  logic [4:0] lvl_m;
  logic       rd_p = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] r;
  int         failures = 0;
  int         cmp_count = 0;
  int         seed = 32'h94EB2566;
  logic [7:0] ofs [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h08,
                          8'h09, 8'h0A, 8'hFF, 8'h06, 8'h07};
  logic [7:0] bitv [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h01};

  periph_model peri_u (.clk_i, .ev_i(ev), .lvl_i(lvl), .ev_o(ev_m),
                       .lvl_o(lvl_m));
  peripheral_irq_flags_enables dut_u (
    .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .timer_one_gate_active_i(lvl_m[0]), .async_receive_full_i(lvl_m[1]),
    .async_transmit_empty_i(lvl_m[2]), .capcomp_one_pwm_i(lvl_m[3]),
    .capcomp_two_pwm_i(lvl_m[4]), .timer_one_overflow_i(ev_m[0]),
    .timer_two_match_i(ev_m[1]), .capcomp_one_event_i(ev_m[2]),
    .sync_port_done_i(ev_m[3]), .conversion_done_i(ev_m[4]),
    .capcomp_two_event_i(ev_m[5]), .cpu_irq_o, .irq_o);

  always #5 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      failures++;
    end
  endtask
  task automatic bus(input logic w, input logic rr, input logic [7:0] a,
                     input logic [7:0] d);
    wr_i <= w;
    rd_i <= rr;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic tick(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  // one-cycle condition; the model adds a cycle before the block sees it
  task automatic fire(input logic [5:0] b);
    ev <= b;
    tick(1);
    ev <= 6'h00;
  endtask
  task automatic pins(input logic [1:0] e);
    tick(4);
    @(negedge clk_i);
    chk("cpu_irq,irq", {6'h00, cpu_irq_o, irq_o}, {6'h00, e});
    @(posedge clk_i);
  endtask
  task automatic finish_test();
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // read data only stand one cycle, so compare at the following low phase
  always @(posedge clk_i) rd_p <= rd_i;
  always @(negedge clk_i) begin
    if (rd_p) chk("rdata", rdata_o, exp_q.pop_front());
  end

  initial begin
    #100us;
    failures++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(3);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    rd(OFS_REQUEST_ONE, 8'h80);
    r = 8'($random(seed));
    wr(OFS_OPTION, r);
    wr(OFS_ENABLE_ONE, ~r);
    wr(OFS_ENABLE_TWO, 8'hFF);
    wr(8'h0A, 8'hFF);
    rd(OFS_OPTION, r);
    rd(OFS_ENABLE_ONE, ~r);
    rd(OFS_ENABLE_TWO, 8'h01);
    rd(8'h0A, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lvl <= {2'b00, i[2:0]};
      tick(2);
      rd(OFS_REQUEST_ONE, {~i[0], 1'b0, i[1], i[2], 4'h0});
    end
    lvl <= 5'h01;
    tick(2);
    wr(OFS_REQUEST_ONE, 8'hFF);
    wr(OFS_REQUEST_TWO, 8'hFF);
    rd(OFS_REQUEST_ONE, 8'h4F);
    rd(OFS_REQUEST_TWO, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(i == 5 ? OFS_REQUEST_TWO : OFS_REQUEST_ONE, 8'h00);
      fire(6'h01 << i);
      tick(3);
      rd(i == 5 ? OFS_REQUEST_TWO : OFS_REQUEST_ONE, bitv[i]);
    end
    wr(OFS_REQUEST_ONE, 8'h00);
    wr(OFS_REQUEST_TWO, 8'h00);
    lvl <= 5'h19;
    tick(2);
    fire(6'h24);
    tick(3);
    rd(OFS_REQUEST_ONE, 8'h00);
    rd(OFS_REQUEST_TWO, 8'h00);
    lvl <= 5'h01;
    ev <= 6'h10;
    tick(1);
    ev <= 6'h00;
    wr(OFS_REQUEST_ONE, 8'h00);
    rd(OFS_REQUEST_ONE, 8'h40);
    wr(OFS_REQUEST_ONE, 8'h00);
    wr(OFS_STATUS_ONE, 8'hFF);
    wr(OFS_STATUS_TWO, 8'hFF);
    wr(OFS_ENABLE_ONE, 8'h01);
    wr(OFS_ENABLE_TWO, 8'h01);
    wr(OFS_MAIN_CONTROL, 8'h80);
    fire(6'h01);
    pins(2'b00);
    wr(OFS_MAIN_CONTROL, 8'hC0);
    pins(2'b10);
    wr(OFS_MAIN_CONTROL, 8'h40);
    wr(OFS_MASK_ONE, 8'h01);
    pins(2'b01);
    rd(OFS_STATUS_ONE, 8'h01);
    wr(OFS_STATUS_ONE, 8'h01);
    wr(OFS_MAIN_CONTROL, 8'hC0);
    wr(OFS_REQUEST_ONE, 8'h00);
    fire(6'h02);
    pins(2'b00);
    wr(OFS_MASK_TWO, 8'h01);
    fire(6'h20);
    pins(2'b11);
    wr(OFS_REQUEST_TWO, 8'h00);
    wr(OFS_ENABLE_ONE, 8'h41);
    pins(2'b01);
    fire(6'h11);
    pins(2'b11);
    tick(2);
    finish_test();
  end
endmodule
`default_nettype wire
